// >>> rtl/rtc_tx_ctrl.sv
// transmit control: clock modes, residual carrier loop, guard timer, power gearing
`timescale 1ns/1ps
// What this block does
// - mode 111 gives continuous carrier, residual sets depth
// - closed loop keeps modulation degree constant
// - 5-bit residual code, higher means deeper
// - no transmit before guard timer expires
// - go set early means send at expiry
// - late go with grid sync waits grid
// - guard timer starts at reception end, except as below
// - no guard start on noise or multi-receive
// - optional guard start at field switch-on
// - transmit only on go flag or command
// - guard setup zero disables the guard timer
// - excursion pattern uses its own clock mode
// - overshoot pattern uses its own residual level
// - periodic gain measurement at configured interval
// - threshold crossing selects another supply gear
// - up to fifteen configured power gears
// - table adjusts wave shaping per gear, protocol
// - modes 000/001/010 give hi-z, low, high
module rtc_tx_ctrl (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// transmitter mode and shaping
	input wire logic [2:0] tx_clock_mode_field,
	input wire logic [4:0] residual_carrier_setting,
	input wire logic [3:0] tau_rise_setting,
	input wire logic [3:0] tau_fall_setting,
	input wire logic envelope,
	// excursion prevention
	input wire logic [7:0] over_excursion_setup,
	input wire logic [7:0] under_excursion_setup,
	input wire logic [2:0] excursion_clock_mode,
	input wire logic [4:0] excursion_residual_level,
	// modulation degree feedback
	input wire logic meas_residual_valid,
	input wire logic [4:0] meas_residual,
	// guard timer and transmit start
	input wire logic [7:0] guard_time_setup,
	input wire logic guard_on_field_start_en,
	input wire logic bit_grid_sync_en,
	input wire logic multi_receive_en,
	input wire logic transmit_go_flag,
	input wire logic transmit_payload_cmd,
	input wire logic rx_end,
	input wire logic field_noise_event,
	input wire logic rf_field_on,
	input wire logic bit_grid_tick,
	input wire logic tx_done,
	// power gearing
	input wire logic [7:0] measure_interval_byte,
	input wire logic [9:0] agc_value,
	input wire logic [9:0] agc_max,
	input wire logic [9:0] agc_min,
	input wire logic [3:0] gear_count,
	input wire logic [12:0] protocol_sel,
	input wire logic lut_wr_en,
	input wire logic [3:0] lut_wr_addr,
	input wire rtc_pkg::rtc_lut_s lut_wr_data,
	// transmitter outputs
	output logic tx1_out_q,
	output logic tx1_oe_q,
	output logic tx2_out_q,
	output logic tx2_oe_q,
	output logic [4:0] residual_drive_q,
	output logic [3:0] tau_rise_q,
	output logic [3:0] tau_fall_q,
	// status
	output logic tx_start_q,
	output logic tx_active_q,
	output logic guard_run_q,
	output logic [3:0] gear_q,
	output logic agc_sample_q
);
	function automatic logic signed [7:0] sm_val(input logic [3:0] d);
		sm_val = d[3] ? -$signed({5'h00, d[2:0]}) : $signed({5'h00, d[2:0]});
	endfunction

	function automatic logic [4:0] sat_code(input logic signed [7:0] v, input logic [4:0] top);
		if (v < 0) begin
			sat_code = 5'h00;
		end else if (v > $signed({3'h0, top})) begin
			sat_code = top;
		end else begin
			sat_code = v[4:0];
		end
	endfunction

	// carrier phase and tick dividers
	localparam int DIV_W = rtc_pkg::DIV_W;
	logic [DIV_W-1:0] car_div_q, g_div_q, m_div_q;
	logic carrier_q;
	wire car_tick = car_div_q == DIV_W'(rtc_pkg::CAR_HALF_CYC - 1);
	wire g_tick = g_div_q == DIV_W'(rtc_pkg::GUARD_TICK_CYC - 1);
	wire m_unit = m_div_q == DIV_W'(rtc_pkg::MEAS_UNIT_CYC - 1);
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			car_div_q <= '0;
			g_div_q <= '0;
			m_div_q <= '0;
			carrier_q <= 1'b0;
		end else begin
			car_div_q <= car_tick ? '0 : car_div_q + 1'b1;
			g_div_q <= g_tick ? '0 : g_div_q + 1'b1;
			m_div_q <= m_unit ? '0 : m_div_q + 1'b1;
			carrier_q <= carrier_q ^ car_tick;
		end
	end

	// excursion prevention: undershoot after pause start, overshoot after pause end
	logic env_q;
	logic [7:0] over_cnt_q, under_cnt_q;
	wire over_on = over_cnt_q != 8'h00;
	wire excur_on = over_on || under_cnt_q != 8'h00;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			env_q <= 1'b1;
			over_cnt_q <= 8'h00;
			under_cnt_q <= 8'h00;
		end else begin
			env_q <= envelope;
			if (envelope && !env_q) begin
				over_cnt_q <= over_excursion_setup;
			end else if (over_on && car_tick) begin
				over_cnt_q <= over_cnt_q - 1'b1;
			end
			if (!envelope && env_q) begin
				under_cnt_q <= under_excursion_setup;
			end else if (under_cnt_q != 8'h00 && car_tick) begin
				under_cnt_q <= under_cnt_q - 1'b1;
			end
		end
	end

	// output stage decode; outside a pause and the excursion windows the carrier runs push-pull
	wire [2:0] mode_sel = excur_on ? excursion_clock_mode : tx_clock_mode_field;
	wire apply_mode = !envelope || excur_on;
	logic o1_d, e1_d, o2_d, e2_d;
	always_comb begin
		o1_d = carrier_q;
		o2_d = !carrier_q;
		e1_d = 1'b1;
		e2_d = 1'b1;
		if (apply_mode) begin
			case (rtc_pkg::rtc_clk_mode_e'(mode_sel))
				rtc_pkg::RTC_MODE_CW: begin
					o1_d = carrier_q;
				end
				rtc_pkg::RTC_MODE_LOW: begin
					o1_d = 1'b0;
					o2_d = 1'b0;
				end
				rtc_pkg::RTC_MODE_HIGH: begin
					o1_d = 1'b1;
					o2_d = 1'b1;
				end
				rtc_pkg::RTC_MODE_HSIDE: begin
					o1_d = 1'b1;
					o2_d = 1'b1;
					e1_d = carrier_q;
					e2_d = !carrier_q;
				end
				rtc_pkg::RTC_MODE_LSIDE: begin
					o1_d = 1'b0;
					o2_d = 1'b0;
					e1_d = !carrier_q;
					e2_d = carrier_q;
				end
				default: begin
					e1_d = 1'b0;
					e2_d = 1'b0;
				end
			endcase
		end
	end

	// power gearing and wave shaping table
	logic [7:0] iv_q;
	logic [3:0] top_gear;
	rtc_pkg::rtc_lut_s lut_q;
	assign top_gear = gear_count == 4'h0 ? 4'h0 : gear_count - 1'b1;
	wire meas_tick = m_unit && (iv_q + 1'b1 >= measure_interval_byte);
	wire gear_up = meas_tick && agc_value > agc_max && gear_q < top_gear;
	wire gear_dn = meas_tick && agc_value < agc_min && gear_q != 4'h0;
	wire awc_use = |(lut_q.mask & protocol_sel);
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			iv_q <= 8'h00;
			gear_q <= 4'h0;
			agc_sample_q <= 1'b0;
		end else begin
			if (m_unit) begin
				iv_q <= meas_tick ? 8'h00 : iv_q + 1'b1;
			end
			agc_sample_q <= meas_tick;
			if (gear_q > top_gear) begin
				gear_q <= top_gear;
			end else if (gear_up) begin
				gear_q <= gear_q + 1'b1;
			end else if (gear_dn) begin
				gear_q <= gear_q - 1'b1;
			end
		end
	end

	rtc_lut_mem u_lut (
		.clk_sys(clk_sys),
		.wr_en(lut_wr_en),
		.wr_addr(lut_wr_addr),
		.wr_data(lut_wr_data),
		.rd_addr(gear_q),
		.rd_data_q(lut_q)
	);

	// residual carrier loop: trim nudges the code until feedback matches target
	logic signed [4:0] trim_q;
	wire [4:0] res_target = over_on ? excursion_residual_level : residual_carrier_setting;
	wire signed [7:0] res_awc = awc_use ? sm_val(lut_q.res_delta) : 8'sh00;
	wire signed [7:0] res_sum = $signed({3'h0, res_target}) + 8'(trim_q) + res_awc;
	wire signed [7:0] rise_sum = $signed({4'h0, tau_rise_setting}) + (awc_use ? sm_val(lut_q.rise_delta) : 8'sh00);
	wire signed [7:0] fall_sum = $signed({4'h0, tau_fall_setting}) + (awc_use ? sm_val(lut_q.fall_delta) : 8'sh00);
	wire trim_inc = meas_residual_valid && !excur_on && meas_residual < res_target && trim_q < rtc_pkg::TRIM_MAX;
	wire trim_dec = meas_residual_valid && !excur_on && meas_residual > res_target && trim_q > -rtc_pkg::TRIM_MAX;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			trim_q <= 5'sh00;
			residual_drive_q <= rtc_pkg::RES_RST;
			tau_rise_q <= 4'h0;
			tau_fall_q <= 4'h0;
			{tx1_out_q, tx1_oe_q, tx2_out_q, tx2_oe_q} <= 4'h0;
		end else begin
			if (trim_inc) begin
				trim_q <= trim_q + 5'sh01;
			end else if (trim_dec) begin
				trim_q <= trim_q - 5'sh01;
			end
			residual_drive_q <= sat_code(res_sum, rtc_pkg::RES_TOP);
			tau_rise_q <= 4'(sat_code(rise_sum, {1'b0, rtc_pkg::TAU_TOP}));
			tau_fall_q <= 4'(sat_code(fall_sum, {1'b0, rtc_pkg::TAU_TOP}));
			{tx1_out_q, tx1_oe_q, tx2_out_q, tx2_oe_q} <= {o1_d, e1_d, o2_d, e2_d};
		end
	end

	// guard timer and transmit start
	logic [7:0] guard_cnt_q;
	logic go_q, go_flag_q, late_q;
	wire guard_start = (rx_end && !field_noise_event && !multi_receive_en)
		|| (rf_field_on && guard_on_field_start_en);
	wire guard_exp = guard_run_q && g_tick && guard_cnt_q == 8'h01;
	wire go_set = transmit_payload_cmd || (transmit_go_flag && !go_flag_q);
	wire grid_ok = !late_q || !bit_grid_sync_en || bit_grid_tick;
	wire start_ok = go_q && !tx_active_q && (!guard_run_q || guard_exp) && grid_ok;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			guard_run_q <= 1'b0;
			guard_cnt_q <= 8'h00;
			go_q <= 1'b0;
			go_flag_q <= 1'b0;
			late_q <= 1'b0;
			tx_start_q <= 1'b0;
			tx_active_q <= 1'b0;
		end else begin
			go_flag_q <= transmit_go_flag;
			if (guard_start) begin
				guard_run_q <= guard_time_setup != 8'h00;
				guard_cnt_q <= guard_time_setup;
			end else if (guard_exp) begin
				guard_run_q <= 1'b0;
			end else if (guard_run_q && g_tick) begin
				guard_cnt_q <= guard_cnt_q - 1'b1;
			end
			if (guard_start || start_ok) begin
				late_q <= 1'b0;
			end else if (guard_exp && !go_q) begin
				late_q <= 1'b1;
			end
			go_q <= go_set || (go_q && !start_ok);
			tx_start_q <= start_ok;
			tx_active_q <= start_ok || (tx_active_q && !tx_done);
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	cw_carrier_a: assert property ((tx_clock_mode_field == 3'h7 && !excur_on)
		|=> tx1_oe_q && tx2_oe_q && tx1_out_q != tx2_out_q)
		else $error("carrier mode did not drive a continuous carrier");
	trim_bound_a: assert property (trim_q <= rtc_pkg::TRIM_MAX && trim_q >= -rtc_pkg::TRIM_MAX)
		else $error("residual trim left its range");
	residual_plain_a: assert property ((!awc_use && trim_q == 5'sh00 && !over_on)
		|=> residual_drive_q == $past(residual_carrier_setting))
		else $error("residual drive differs from setting");
	guard_hold_a: assert property ((guard_run_q && !guard_exp) |=> !tx_start_q)
		else $error("transmit started while guard timer ran");
	exact_start_a: assert property ((guard_exp && go_q && !tx_active_q) |=> tx_start_q)
		else $error("transmit did not start at guard expiry");
	grid_wait_a: assert property ((late_q && bit_grid_sync_en && !bit_grid_tick) |=> !tx_start_q)
		else $error("late transmit started off the bit grid");
	guard_load_a: assert property ((rx_end && !field_noise_event && !multi_receive_en
		&& guard_time_setup != 8'h00) |=> guard_run_q && guard_cnt_q == $past(guard_time_setup))
		else $error("guard timer not loaded at reception end");
	noise_skip_a: assert property ((!guard_run_q && rx_end && (field_noise_event || multi_receive_en)
		&& !(rf_field_on && guard_on_field_start_en)) |=> !guard_run_q)
		else $error("guard timer started on noise or multi-receive");
	field_load_a: assert property ((rf_field_on && guard_on_field_start_en
		&& guard_time_setup != 8'h00) |=> guard_run_q)
		else $error("guard timer not started at field switch-on");
	no_self_a: assert property (!go_q |=> !tx_start_q)
		else $error("transmit started without request");
	zero_guard_a: assert property ((guard_time_setup == 8'h00 && !guard_run_q && go_q
		&& !tx_active_q && !late_q) |=> tx_start_q)
		else $error("zero guard setup still delayed transmit");
	excur_mode_a: assert property ((over_on && excursion_clock_mode == 3'h1) |=> tx1_oe_q && !tx1_out_q)
		else $error("excursion clock mode not applied");
	excur_res_a: assert property ((over_on && !awc_use && trim_q == 5'sh00)
		|=> residual_drive_q == $past(excursion_residual_level))
		else $error("overshoot residual level not applied");
	meas_gap_a: assert property (meas_tick |=> !meas_tick [*8])
		else $error("measurements too close together");
	gear_up_a: assert property ((gear_up && gear_q <= top_gear) |=> gear_q == $past(gear_q) + 4'h1)
		else $error("gear did not step up on high gain");
	tau_plain_a: assert property (!awc_use |=> tau_rise_q == $past(tau_rise_setting))
		else $error("rise shaping changed without table hit");
	hiz_mode_a: assert property ((!envelope && !excur_on && tx_clock_mode_field == 3'h0)
		|=> !tx1_oe_q && !tx2_oe_q)
		else $error("high impedance mode still drives");

	start_c: cover property (guard_exp && go_q ##1 tx_start_q);
	gear_c: cover property (gear_up);
	excur_c: cover property (over_on && !envelope ##1 1'b1);
endmodule // rtc_tx_ctrl

// >>> rtl/rtc_pkg.sv
// shared constants and types for the rf transmit control block
package rtc_pkg;
	localparam int CLK_NS = 10;
	// half period of the internal carrier phase, in ns
	localparam int CAR_HALF_NS = 40;
	localparam int CAR_HALF_CYC = (CAR_HALF_NS + CLK_NS - 1) / CLK_NS;
	// one guard timer tick, in ns
	localparam int GUARD_TICK_NS = 590;
	localparam int GUARD_TICK_CYC = (GUARD_TICK_NS + CLK_NS - 1) / CLK_NS;
	// one unit of the measurement interval byte, in ns
	localparam int MEAS_UNIT_NS = 10000;
	localparam int MEAS_UNIT_CYC = MEAS_UNIT_NS / CLK_NS;
	localparam int DIV_W = 10;
	localparam logic [4:0] RES_TOP = 5'h1f;
	localparam logic [3:0] TAU_TOP = 4'hf;
	localparam logic signed [4:0] TRIM_MAX = 5'sh07;
	localparam int GEAR_N = 16;
	localparam logic [3:0] GEAR_LAST = 4'hf;
	localparam logic [4:0] RES_RST = 5'h00;

	typedef enum logic [2:0] {
		RTC_MODE_HIZ = 3'b000,
		RTC_MODE_LOW = 3'b001,
		RTC_MODE_HIGH = 3'b010,
		RTC_MODE_LSIDE = 3'b101,
		RTC_MODE_HSIDE = 3'b110,
		RTC_MODE_CW = 3'b111
	} rtc_clk_mode_e;

	// one wave shaping table entry, deltas are sign bit plus 3-bit magnitude
	typedef struct packed {
		logic [12:0] mask;
		logic [3:0] res_delta;
		logic [3:0] rise_delta;
		logic [3:0] fall_delta;
	} rtc_lut_s;
endpackage

// >>> rtl/rtc_lut_mem.sv
// per-gear wave shaping table with registered read data
`timescale 1ns/1ps
module rtc_lut_mem (
	// clock
	input wire logic clk_sys,
	// write port
	input wire logic wr_en,
	input wire logic [3:0] wr_addr,
	input wire rtc_pkg::rtc_lut_s wr_data,
	// read port
	input wire logic [3:0] rd_addr,
	output rtc_pkg::rtc_lut_s rd_data_q
);
	rtc_pkg::rtc_lut_s mem_q [rtc_pkg::GEAR_N];

	// contents come from the loader, so no reset on the array
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
		rd_data_q <= mem_q[rd_addr];
	end
endmodule // rtc_lut_mem

// >>> tb/rtc_ant_model.sv
// behavioural antenna network: residual and gain feedback to the transmit control
`timescale 1ns/1ps
module rtc_ant_model (
	// clock
	input wire logic clk_sys,
	// transmitter pins
	input wire logic tx1_out,
	input wire logic tx1_oe,
	input wire logic tx2_out,
	input wire logic tx2_oe,
	input wire logic [4:0] residual_drive,
	// bench control
	input wire logic meas_req,
	input wire logic [4:0] meas_loss,
	input wire logic [9:0] load_level,
	// feedback
	output logic meas_valid,
	output logic [4:0] meas_residual,
	output logic [9:0] agc_value,
	output logic [1:0] pin_level
);
	logic [1:0] last_q = 2'h0;
	// a released pin keeps no value, so show the inverse of the last one
	assign pin_level = {tx2_oe ? tx2_out : ~last_q[1], tx1_oe ? tx1_out : ~last_q[0]};
	// a lossy network reaches less depth than the code asks for
	assign meas_residual = residual_drive - meas_loss;
	assign meas_valid = meas_req;
	assign agc_value = load_level;
	// only a driven pin updates the remembered level, so a released one holds still
	always_ff @(posedge clk_sys) begin
		if (tx1_oe) begin
			last_q[0] <= tx1_out;
		end
		if (tx2_oe) begin
			last_q[1] <= tx2_out;
		end
	end
endmodule // rtc_ant_model

// >>> tb/rtc_tx_ctrl_tb.sv
// self-checking bench for the rf transmit control block
`timescale 1ns/1ps
module rtc_tx_ctrl_tb;
	logic clk_sys = 1'b0, rst_b = 1'b0, envelope = 1'b1, meas_residual_valid, meas_req = 1'b0;
	logic guard_on_field_start_en = 1'b0, bit_grid_sync_en = 1'b0, multi_receive_en = 1'b0;
	logic transmit_go_flag = 1'b0, transmit_payload_cmd = 1'b0, rx_end = 1'b0, field_noise_event = 1'b0;
	logic rf_field_on = 1'b0, bit_grid_tick = 1'b0, tx_done = 1'b0, lut_wr_en = 1'b0;
	logic [2:0] tx_clock_mode_field = 3'h7, excursion_clock_mode = 3'h1;
	logic [4:0] residual_carrier_setting = 5'h00, excursion_residual_level = 5'h1f, meas_residual, meas_loss = 5'h00;
	logic [3:0] tau_rise_setting = 4'h3, tau_fall_setting = 4'h5, gear_count = 4'h3, lut_wr_addr = 4'h0;
	logic [7:0] over_excursion_setup = 8'h00, under_excursion_setup = 8'h00, guard_time_setup = 8'h00;
	logic [7:0] measure_interval_byte = 8'h01;
	logic [9:0] agc_value, agc_max = 10'h200, agc_min = 10'h100, load = 10'h180;
	logic [12:0] protocol_sel = 13'h0001;
	rtc_pkg::rtc_lut_s lut_wr_data = '0;
	logic tx1_out_q, tx1_oe_q, tx2_out_q, tx2_oe_q, tx_start_q, tx_active_q, guard_run_q, agc_sample_q;
	logic [4:0] residual_drive_q;
	logic [3:0] tau_rise_q, tau_fall_q, gear_q;
	logic [1:0] pin_level;
	int err_count = 0;
	int total_checks = 0;

	rtc_tx_ctrl i_rtc_tx_ctrl (.clk_sys, .rst_b, .tx_clock_mode_field, .residual_carrier_setting, .tau_rise_setting,
		.tau_fall_setting, .envelope, .over_excursion_setup, .under_excursion_setup, .excursion_clock_mode,
		.excursion_residual_level, .meas_residual_valid, .meas_residual, .guard_time_setup, .guard_on_field_start_en,
		.bit_grid_sync_en, .multi_receive_en, .transmit_go_flag, .transmit_payload_cmd, .rx_end, .field_noise_event,
		.rf_field_on, .bit_grid_tick, .tx_done, .measure_interval_byte, .agc_value, .agc_max, .agc_min, .gear_count,
		.protocol_sel, .lut_wr_en, .lut_wr_addr, .lut_wr_data, .tx1_out_q, .tx1_oe_q, .tx2_out_q, .tx2_oe_q,
		.residual_drive_q, .tau_rise_q, .tau_fall_q, .tx_start_q, .tx_active_q, .guard_run_q, .gear_q, .agc_sample_q);
	rtc_ant_model i_rtc_ant_model (.clk_sys, .tx1_out(tx1_out_q), .tx1_oe(tx1_oe_q), .tx2_out(tx2_out_q),
		.tx2_oe(tx2_oe_q), .residual_drive(residual_drive_q), .meas_req, .meas_loss, .load_level(load),
		.meas_valid(meas_residual_valid), .meas_residual, .agc_value, .pin_level);

	always #5 clk_sys = ~clk_sys;

	// inputs change 1 ns after the edge so no process order can matter
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task automatic wait_hi(ref logic s, input int lim, output int n);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic chk_val(input string what, input logic [4:0] exp, input logic [4:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic t_start;
		int n;
		tick(5);
		chk_bit("idle start", 1'b0, tx_start_q);
		pulse(transmit_payload_cmd);
		wait_hi(tx_start_q, 4, n);
		chk_bit("cmd start", 1'b1, tx_start_q);
		chk_bit("active", 1'b1, tx_active_q);
		pulse(tx_done);
		chk_bit("active end", 1'b0, tx_active_q);
		$display("test start done");
	endtask
	task automatic t_guard;
		int n;
		guard_time_setup <= 8'h02;
		pulse(rx_end);
		chk_bit("guard run", 1'b1, guard_run_q);
		transmit_go_flag <= 1'b1;
		wait_hi(tx_start_q, 130, n);
		// two ticks of 59 cycles with a partial first one
		chk_bit("guard span", 1'b1, n >= 60 && n <= 120);
		chk_bit("start at expiry", 1'b0, guard_run_q);
		transmit_go_flag <= 1'b0;
		pulse(tx_done);
		$display("test guard done");
	endtask
	task automatic t_hold;
		int n;
		field_noise_event <= 1'b1;
		pulse(rx_end);
		chk_bit("noise restart", 1'b0, guard_run_q);
		field_noise_event <= 1'b0;
		multi_receive_en <= 1'b1;
		pulse(rx_end);
		chk_bit("multi receive", 1'b0, guard_run_q);
		multi_receive_en <= 1'b0;
		pulse(rf_field_on);
		chk_bit("field on unarmed", 1'b0, guard_run_q);
		guard_on_field_start_en <= 1'b1;
		bit_grid_sync_en <= 1'b1;
		pulse(rf_field_on);
		chk_bit("field on", 1'b1, guard_run_q);
		tick(130);
		chk_bit("no go", 1'b0, tx_active_q);
		transmit_go_flag <= 1'b1;
		tick(6);
		chk_bit("grid wait", 1'b0, tx_active_q);
		pulse(bit_grid_tick);
		wait_hi(tx_start_q, 4, n);
		chk_bit("grid start", 1'b1, tx_start_q);
		transmit_go_flag <= 1'b0;
		bit_grid_sync_en <= 1'b0;
		pulse(tx_done);
		$display("test hold done");
	endtask
	task automatic t_modes;
		logic v;
		logic [4:0] codes [3] = '{5'h00, 5'h0f, 5'h1f};
		envelope <= 1'b0;
		for (int m = 0; m < 3; m++) begin
			tx_clock_mode_field <= m[2:0];
			tick(3);
			chk_bit("tx1 enable", m != 0, tx1_oe_q);
			chk_bit("tx2 enable", m != 0, tx2_oe_q);
			chk_bit("tx1 level", m == 2, tx1_out_q & tx1_oe_q);
			chk_bit("tx2 level", m == 2, tx2_out_q & tx2_oe_q);
		end
		tx_clock_mode_field <= 3'h6;
		tick(3);
		chk_bit("high side", 1'b1, tx1_out_q & tx2_out_q & (tx1_oe_q ^ tx2_oe_q));
		// a released pin reads low after being driven high
		chk_bit("pin follows enable", tx1_oe_q, pin_level[0]);
		tx_clock_mode_field <= 3'h5;
		tick(3);
		chk_bit("low side", 1'b1, !(tx1_out_q | tx2_out_q) & (tx1_oe_q ^ tx2_oe_q));
		tx_clock_mode_field <= 3'h7;
		tick(2);
		v = tx1_out_q;
		tick(4);
		chk_bit("carrier runs", ~v, tx1_out_q);
		residual_carrier_setting <= 5'h0f;
		over_excursion_setup <= 8'h04;
		envelope <= 1'b1;
		tick(3);
		// a running carrier would drive one of the pair high
		chk_bit("exc mode", 1'b0, tx1_out_q | tx2_out_q);
		chk_val("exc level", 5'h1f, residual_drive_q);
		tick(30);
		chk_val("level after", 5'h0f, residual_drive_q);
		for (int i = 0; i < 3; i++) begin
			residual_carrier_setting <= codes[i];
			tick(3);
			chk_val("residual code", codes[i], residual_drive_q);
		end
		residual_carrier_setting <= 5'h0a;
		meas_loss <= 5'h02;
		tick(3);
		pulse(meas_req);
		tick(3);
		chk_val("loop raise", 5'h0b, residual_drive_q);
		meas_loss <= 5'h00;
		pulse(meas_req);
		tick(3);
		chk_val("loop lower", 5'h0a, residual_drive_q);
		$display("test modes done");
	endtask
	task automatic t_gear;
		int n;
		logic [3:0] exp [6] = '{4'h1, 4'h2, 4'h2, 4'h1, 4'h0, 4'h0};
		load <= 10'h300;
		tick(2);
		for (int i = 0; i < 6; i++) begin
			if (i == 3)
				load <= 10'h080;
			wait_hi(agc_sample_q, 1100, n);
			chk_val("gear", {1'b0, exp[i]}, {1'b0, gear_q});
			tick(3);
			if (i == 0) begin
				chk_val("gear residual", 5'h0c, residual_drive_q);
				chk_val("gear rise", 5'h02, {1'b0, tau_rise_q});
				chk_val("gear fall", 5'h08, {1'b0, tau_fall_q});
			end
		end
		$display("test gear done");
	endtask

	initial begin
		tick(10);
		// the outputs leave reset on the first edge after release, so look while reset holds
		chk_bit("reset enable", 1'b0, tx1_oe_q);
		chk_val("reset gear", 5'h00, {1'b0, gear_q});
		rst_b <= 1'b1;
		tick(1);
		// only gear 1 hits: residual plus two, rise minus one, fall plus three
		for (int i = 0; i < 16; i++) begin
			lut_wr_en <= 1'b1;
			lut_wr_addr <= i[3:0];
			lut_wr_data <= '{(i == 1) ? 13'h1fff : 13'h0000, (i == 1) ? 4'h2 : 4'h0, (i == 1) ? 4'h9 : 4'h0,
				(i == 1) ? 4'h3 : 4'h0};
			tick(1);
		end
		lut_wr_en <= 1'b0;
		t_start;
		t_guard;
		t_hold;
		t_modes;
		t_gear;
		end_sim;
	end
	// about 6000 cycles of tests, so 20000 is ample
	initial begin
		#200_000;
		err_count++;
		end_sim;
	end
endmodule // rtc_tx_ctrl_tb
